// *** design/acr_pkg.sv ***
// Package with register map, field positions and timing for the config registers
package acr_pkg;
  // Register offsets on the serial port (4-bit address)
  localparam logic [3:0] OFS_PAIR67 = 4'h3;
  localparam logic [3:0] OFS_CHSEL = 4'h4;
  localparam logic [3:0] OFS_SETUP = 4'h5;
  localparam logic [3:0] OFS_INTEN = 4'h6;
  localparam logic [3:0] OFS_STAT = 4'h7;
  localparam logic [3:0] OFS_SRST = 4'h9;
  // Frame command codes in the two leading bits
  localparam logic [1:0] CMD_ADC = 2'h0;
  localparam logic [1:0] CMD_RD = 2'h1;
  localparam logic [1:0] CMD_WR = 2'h2;
  // Writable masks and reset values
  localparam logic [7:0] PAIR67_MASK = 8'h3F;
  localparam logic [7:0] CHSEL_MASK = 8'h07;
  localparam logic [7:0] PAIR67_RST = 8'h00;
  localparam logic [7:0] CHSEL_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [3:0] INTEN_RST = 4'h0;
  localparam logic [7:0] SRST_KEY = 8'hAA;
  // Field positions
  localparam int P67_G7 = 4;
  localparam int P67_ODD6 = 3;
  localparam int P67_DIFF = 2;
  localparam int P67_G6 = 0;
  localparam int SU_AVG = 5;
  localparam int SU_EDGE = 4;
  localparam int SU_POL = 3;
  localparam int SU_BUSY = 2;
  localparam int SU_FIFO = 1;
  localparam int SU_SRC = 0;
  localparam int IE_PD = 7;
  localparam int IE_NEMPTY = 3;
  localparam int IE_FULL = 2;
  localparam int IE_SCAN = 1;
  localparam int IE_DRDY = 0;
  // Edge interrupt pulse width
  localparam int CLK_NS = 10;
  localparam int PULSE_NS = 250;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Results needed per delivered value for an averaging code
  function automatic logic [4:0] avg_len(input logic [2:0] code);
    case (code[1:0])
      2'h1: avg_len = 5'h04;
      2'h2: avg_len = 5'h08;
      2'h3: avg_len = 5'h10;
      default: avg_len = 5'h01;
    endcase
  endfunction
endpackage

// *** design/acr_regs.sv ***
// Serial configuration and status register bank of the acquisition converter
`timescale 1ns/10ps
//
// Contract
// - Two-bit gain codes for channels seven, six
// - Bit three selects channel six odd polarity
// - Bit two makes the pair differential
// - Mux channel or scan start, default zero
// - Setup bits seven to five choose averaging
// - Setup bit four: level or 250ns pulse
// - Setup bit three sets shared pin polarity
// - Setup bit two: interrupt or busy function
// - Setup bit one enables result FIFO storage
// - Setup bit zero: pin or read starts conversion
// - Power-down bit seven; bits six-four read zero
// - FIFO not empty enable and flag
// - FIFO full enable and flag
// - Scan ready enable and flag, auto only
// - Data ready enable and flag
// - Status high nibble is FIFO level
// - Status not-empty and full bits
// - Status scan and data ready bits
// - Data ready after whole average completes
// - Reset, or AAh unless powered down, restores defaults, clears core
module acr_regs #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic ce, // Clock enable, freezes all state when low except what reset or a pending software reset clears
  input wire logic sclk, // Serial clock from host
  input wire logic cs_n, // Serial select, low active
  input wire logic sdin, // Serial data in
  output logic sdout, // Serial data out
  output logic sdout_oe, // Drive enable for sdout
  input wire logic conversion_launch_pin, // External start pin
  input wire logic conv_busy, // Core is converting
  input wire logic result_done, // Core finished one result
  input wire logic scan_done, // Core finished a scan
  input wire logic auto_scan, // Core in auto channel and trigger mode
  input wire logic [3:0] fifo_level, // Entries in result FIFO
  output logic [1:0] ch7_gain, // Channel seven gain code
  output logic [1:0] ch6_gain, // Channel six gain code
  output logic pair67_diff, // Pair is differential
  output logic ch6_odd, // Channel six odd polarity
  output logic [2:0] mux_channel, // Selected or start channel
  output logic [2:0] avg_mode, // Averaging code
  output logic fifo_enable, // Store results in FIFO
  output logic power_down, // Power-down idle
  output logic conv_start, // Start one conversion, pulse
  output logic core_clear, // Clear FIFO and abort conversion, pulse
  output logic busy_int_pin // Shared status or interrupt pin
);

  // Pin synchronisers, first stage feeds only the second
  logic [1:0] sclk_sy, cs_sy, sdi_sy, lp_sy;
  logic sclk_d, lp_d; // Edge history of synced pins
  logic [4:0] bit_cnt_reg; // Rising edges seen in frame
  logic [15:0] in_sr_reg; // Incoming bits
  logic [7:0] out_sr_reg; // Outgoing read data
  logic rd_frame_reg; // Current frame is a register read
  logic [7:0] pair67_reg, chsel_reg, setup_reg;
  logic pd_reg; // Power-down
  logic [3:0] inten_reg; // Interrupt enables
  logic [3:0] iflag_reg; // Interrupt generated flags
  logic drdy_reg, sdrdy_reg; // Status ready bits
  logic [4:0] avg_cnt_reg; // Results counted toward an average
  logic srst_reg; // Software reset, one cycle
  logic [5:0] pulse_cnt_reg; // Edge pulse remaining
  logic int_any_d; // Previous interrupt level
  logic sdout_reg, oe_reg, start_reg, clear_reg, pin_reg;

  // Edge and frame decoding
  wire sclk_rise = sclk_sy[1] & ~sclk_d;
  wire sclk_fall = ~sclk_sy[1] & sclk_d;
  wire sel = ~cs_sy[1];
  wire [15:0] sh_next = {in_sr_reg[14:0], sdi_sy[1]};
  wire hdr_done = sel & sclk_rise & (bit_cnt_reg == 5'd7);
  wire frm_done = sel & sclk_rise & (bit_cnt_reg == 5'd15);
  wire [1:0] f_cmd = sh_next[15:14];
  wire [3:0] f_adr = sh_next[13:10];
  wire [7:0] f_dat = sh_next[7:0];
  wire [3:0] h_adr = sh_next[5:2];
  wire h_rd = sh_next[7:6] == acr_pkg::CMD_RD;
  wire wr_en = frm_done & (f_cmd == acr_pkg::CMD_WR);
  wire wr_p67 = wr_en & (f_adr == acr_pkg::OFS_PAIR67);
  wire wr_chs = wr_en & (f_adr == acr_pkg::OFS_CHSEL);
  wire wr_su = wr_en & (f_adr == acr_pkg::OFS_SETUP);
  wire wr_ie = wr_en & (f_adr == acr_pkg::OFS_INTEN);
  // Software reset is refused while powered down
  wire wr_rst = wr_en & (f_adr == acr_pkg::OFS_SRST) & (f_dat == acr_pkg::SRST_KEY)
    & ~pd_reg;
  wire adc_rd = frm_done & (f_cmd == acr_pkg::CMD_ADC);
  wire rd_ie = hdr_done & h_rd & (h_adr == acr_pkg::OFS_INTEN);
  wire clr = reset | srst_reg;

  // Read data mux; unmapped and reset register read zero
  wire [7:0] stat_val = {fifo_level, fifo_level != 4'h0,
    fifo_level == 4'(FIFO_DEPTH), sdrdy_reg, drdy_reg};
  wire [7:0] rd_data =
    (h_adr == acr_pkg::OFS_PAIR67) ? pair67_reg :
    (h_adr == acr_pkg::OFS_CHSEL) ? chsel_reg :
    (h_adr == acr_pkg::OFS_SETUP) ? setup_reg :
    (h_adr == acr_pkg::OFS_INTEN) ? {pd_reg, 3'h0, iflag_reg} :
    (h_adr == acr_pkg::OFS_STAT) ? stat_val : 8'h00;

  // Interrupt events, each gated by its enable
  wire [4:0] avg_need = acr_pkg::avg_len(setup_reg[acr_pkg::SU_AVG +: 3]);
  wire avg_last = result_done & (avg_cnt_reg + 5'h01 >= avg_need);
  wire [3:0] ev = {fifo_level != 4'h0, fifo_level == 4'(FIFO_DEPTH),
    scan_done & auto_scan, avg_last};
  wire int_any = |iflag_reg;
  wire pol_hi = setup_reg[acr_pkg::SU_POL];
  wire edge_md = setup_reg[acr_pkg::SU_EDGE];
  wire lp_rise = lp_sy[1] & ~lp_d;
  // Shared pin: busy, edge pulse or level, then polarity
  wire pin_act = setup_reg[acr_pkg::SU_BUSY] ? conv_busy :
    (edge_md ? (pulse_cnt_reg != 6'h0) : int_any);
  wire pin_next = pol_hi ? pin_act : ~pin_act;

  // Pin synchronisers and edge history
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_sy <= 2'h0;
      cs_sy <= 2'h3;
      sdi_sy <= 2'h0;
      lp_sy <= 2'h0;
      sclk_d <= 1'b0;
      lp_d <= 1'b0;
    end else if (ce) begin
      sclk_sy <= {sclk_sy[0], sclk};
      cs_sy <= {cs_sy[0], cs_n};
      sdi_sy <= {sdi_sy[0], sdin};
      lp_sy <= {lp_sy[0], conversion_launch_pin};
      sclk_d <= sclk_sy[1];
      lp_d <= lp_sy[1];
    end
  end

  // Serial shifter: sample on rising sclk, drive on falling
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_reg <= 5'h0;
      in_sr_reg <= 16'h0;
      out_sr_reg <= 8'h0;
      rd_frame_reg <= 1'b0;
      sdout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ce) begin
      oe_reg <= sel;
      if (!sel) begin
        // Deselect ends the frame
        bit_cnt_reg <= 5'h0;
        rd_frame_reg <= 1'b0;
        sdout_reg <= 1'b0;
      end else if (sclk_rise) begin
        in_sr_reg <= sh_next;
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (hdr_done) begin
          rd_frame_reg <= h_rd;
          out_sr_reg <= rd_data;
        end
      end else if (sclk_fall && rd_frame_reg && bit_cnt_reg >= 5'd8) begin
        sdout_reg <= out_sr_reg[7];
        out_sr_reg <= {out_sr_reg[6:0], 1'b0};
      end
    end
  end

  // Configuration registers; masked bits stay zero
  always_ff @(posedge clk) begin
    if (clr) begin
      pair67_reg <= acr_pkg::PAIR67_RST;
      chsel_reg <= acr_pkg::CHSEL_RST;
      setup_reg <= acr_pkg::SETUP_RST;
      inten_reg <= acr_pkg::INTEN_RST;
      pd_reg <= 1'b0;
    end else if (ce) begin
      if (wr_p67) begin
        pair67_reg <= f_dat & acr_pkg::PAIR67_MASK;
      end
      if (wr_chs) begin
        chsel_reg <= f_dat & acr_pkg::CHSEL_MASK;
      end
      if (wr_su) begin
        setup_reg <= f_dat;
      end
      if (wr_ie) begin
        pd_reg <= f_dat[acr_pkg::IE_PD];
        inten_reg <= f_dat[3:0];
      end
    end
  end

  // Flags: set wins over the clear made by reading the register
  always_ff @(posedge clk) begin
    if (clr) begin
      iflag_reg <= 4'h0;
      drdy_reg <= 1'b0;
      sdrdy_reg <= 1'b0;
      avg_cnt_reg <= 5'h0;
    end else if (ce) begin
      iflag_reg <= ((rd_ie ? 4'h0 : iflag_reg) | (ev & inten_reg));
      drdy_reg <= avg_last | (drdy_reg & ~adc_rd);
      sdrdy_reg <= (scan_done & auto_scan) | (sdrdy_reg & ~adc_rd);
      if (result_done) begin
        avg_cnt_reg <= avg_last ? 5'h0 : avg_cnt_reg + 5'h01;
      end
    end
  end

  // Shared pin, edge pulse timer, conversion start and core clear
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_cnt_reg <= 6'h0;
      int_any_d <= 1'b0;
      pin_reg <= 1'b1;
      start_reg <= 1'b0;
      // Held high through reset so the core clear still comes from a flop
      clear_reg <= 1'b1;
      srst_reg <= 1'b0;
    end else if (ce) begin
      srst_reg <= wr_rst;
      clear_reg <= wr_rst;
      int_any_d <= int_any;
      if (int_any && !int_any_d) begin
        pulse_cnt_reg <= 6'(acr_pkg::PULSE_CYC);
      end else if (pulse_cnt_reg != 6'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 6'h01;
      end
      pin_reg <= pin_next;
      // Pin or serial result read launches, never while powered down
      start_reg <= ~pd_reg & (setup_reg[acr_pkg::SU_SRC] ? adc_rd : lp_rise);
    end
  end

  // Outputs come straight from flip-flops
  assign sdout = sdout_reg;
  assign sdout_oe = oe_reg;
  assign ch7_gain = pair67_reg[acr_pkg::P67_G7 +: 2];
  assign ch6_gain = pair67_reg[acr_pkg::P67_G6 +: 2];
  assign pair67_diff = pair67_reg[acr_pkg::P67_DIFF];
  assign ch6_odd = pair67_reg[acr_pkg::P67_ODD6];
  assign mux_channel = chsel_reg[2:0];
  assign avg_mode = setup_reg[acr_pkg::SU_AVG +: 3];
  assign fifo_enable = setup_reg[acr_pkg::SU_FIFO];
  assign power_down = pd_reg;
  assign conv_start = start_reg;
  assign core_clear = clear_reg;
  assign busy_int_pin = pin_reg;

  // Checks, valid while ce stays high
  AST_P67_WR: assert property (@(posedge clk) disable iff (reset || !ce)
    wr_p67 |=> pair67_reg == ($past(f_dat) & 8'h3F))
    else $error("pair setup write not stored");
  AST_CHSEL_WR: assert property (@(posedge clk) disable iff (reset || !ce)
    wr_chs |=> mux_channel == $past(f_dat[2:0]))
    else $error("channel select write not stored");
  AST_SRST: assert property (@(posedge clk) disable iff (reset || !ce)
    wr_rst |=> ##1 (setup_reg == 8'h00 && pair67_reg == 8'h00 && !fifo_enable))
    else $error("software reset left configuration");
  AST_EDGE_PULSE: assert property (@(posedge clk) disable iff (reset || !ce)
    (int_any && !int_any_d) |=> pulse_cnt_reg == 6'd25 ##24 pulse_cnt_reg == 6'd1)
    else $error("edge pulse width wrong");
  AST_LEVEL_PIN: assert property (@(posedge clk) disable iff (reset || !ce)
    (!setup_reg[2] && !setup_reg[4] && $stable(setup_reg)) |=>
      busy_int_pin == ($past(int_any) ~^ $past(pol_hi)))
    else $error("level pin wrong");
  AST_BUSY_PIN: assert property (@(posedge clk) disable iff (reset || !ce)
    setup_reg[2] |=> busy_int_pin == ($past(conv_busy) ~^ $past(pol_hi)))
    else $error("busy pin wrong");
  AST_PIN_START: assert property (@(posedge clk) disable iff (reset || !ce)
    (lp_rise && !setup_reg[0] && !pd_reg) |=> conv_start)
    else $error("pin start lost");
  AST_FULL_FLAG: assert property (@(posedge clk) disable iff (reset || !ce)
    (fifo_level == 4'(FIFO_DEPTH) && inten_reg[2] && !srst_reg) |=> iflag_reg[2])
    else $error("full flag not set");
  AST_DRDY_AVG: assert property (@(posedge clk) disable iff (reset || !ce)
    (result_done && avg_cnt_reg + 5'h01 < avg_need && !srst_reg) |=> !$rose(drdy_reg))
    else $error("ready before average done");
  // Masked bits never hold a one, whatever the host wrote
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (reset || !ce)
    pair67_reg[7:6] == 2'h0 && chsel_reg[7:3] == 5'h00)
    else $error("unused register bits not zero");
  // No conversion may launch while powered down
  AST_PD_NO_START: assert property (@(posedge clk) disable iff (reset || !ce)
    pd_reg |=> !conv_start)
    else $error("start while powered down");
  // Reading the interrupt register clears flags unless a new event arrives
  AST_FLAG_RD_CLR: assert property (@(posedge clk) disable iff (reset || !ce)
    (rd_ie && (ev & inten_reg) == 4'h0 && !srst_reg) |=> iflag_reg == 4'h0)
    else $error("flags not cleared by read");
  COV_START: cover property (@(posedge clk) conv_start);
  COV_WRITE: cover property (@(posedge clk) wr_su);
  COV_READ: cover property (@(posedge clk) hdr_done && h_rd);
  COV_SRST: cover property (@(posedge clk) wr_rst);
  COV_EDGE: cover property (@(posedge clk) edge_md && pulse_cnt_reg == 6'd1);
endmodule

// *** testbench/acr_host.sv ***
// Serial host model that sends register frames to the bank
`timescale 1ns/10ps
module acr_host (
  output logic sclk, // Serial clock, still between frames
  output logic cs_n, // Select, low active
  output logic sdin, // Data toward the bank
  input wire logic sdout // Data from the bank
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdin = 1'b0;
  end
  // One frame, MSB first, 125 ns bit time; only bank registers while idle
  task automatic xfer(input logic [1:0] cmd, input logic [3:0] addr, input logic [7:0] wd,
      output logic [7:0] rd);
    logic [15:0] word;
    word = {cmd, addr, 2'h0, wd};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdin = word[i];
      #62.5 sclk = 1'b1;
      // Answer bits come on the rises after the header
      if (i < 8) rd[i] = sdout;
      #62.5 sclk = 1'b0;
    end
    // Released line flips so no stale level is mistaken for data
    sdin = ~sdin;
    #125 cs_n = 1'b1;
    #250;
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the configuration and status register bank
`timescale 1ns/10ps
module testbench;
  logic clk, reset, ce, sclk, cs_n, sdin, sdout, sdout_oe; // Clock, reset, link
  logic launch, conv_busy, result_done, scan_done, auto_scan; // Core inputs
  logic [3:0] fifo_level; // FIFO entries
  logic [1:0] ch7_gain, ch6_gain; // Gain codes
  logic pair67_diff, ch6_odd, fifo_enable, power_down, conv_start, core_clear, pin;
  logic [2:0] mux_channel, avg_mode; // Channel and averaging
  logic [7:0] rd; // Last read data
  int failures, n_checks, n_start, n_clear, n_high, n_oe; // Tallies
  typedef struct {logic [3:0] a; logic [7:0] w, r; logic [13:0] p;} acr_row_t;
  // Address, written, read back, packed config outputs; rows build on each other
  acr_row_t rows [6] = '{'{4'h3, 8'hFF, 8'h3F, 14'h3F00}, '{4'h3, 8'h16, 8'h16, 14'h1A00},
    '{4'h4, 8'hFF, 8'h07, 14'h1AE0}, '{4'h5, 8'hA2, 8'hA2, 14'h1AF6},
    '{4'hF, 8'hFF, 8'h00, 14'h1AF6}, '{4'h6, 8'h8F, 8'h80, 14'h1AF7}};
  wire [13:0] ports = {ch7_gain, ch6_gain, pair67_diff, ch6_odd, mux_channel, avg_mode,
    fifo_enable, power_down}; // Config outputs packed as in the rows
  acr_regs #(.FIFO_DEPTH(8)) DUT (.clk(clk), .reset(reset), .ce(ce), .sclk(sclk),
    .cs_n(cs_n), .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe),
    .conversion_launch_pin(launch), .conv_busy(conv_busy), .result_done(result_done),
    .scan_done(scan_done), .auto_scan(auto_scan), .fifo_level(fifo_level),
    .ch7_gain(ch7_gain), .ch6_gain(ch6_gain), .pair67_diff(pair67_diff), .ch6_odd(ch6_odd),
    .mux_channel(mux_channel), .avg_mode(avg_mode), .fifo_enable(fifo_enable),
    .power_down(power_down), .conv_start(conv_start), .core_clear(core_clear),
    .busy_int_pin(pin));
  acr_host host (.sclk(sclk), .cs_n(cs_n), .sdin(sdin), .sdout(sdout));
  // Pulse and level tallies on the design's outputs
  always @(posedge clk) begin
    if (conv_start === 1'b1) n_start++;
    if (core_clear === 1'b1) n_clear++;
    if (pin === 1'b1) n_high++;
    if (sdout_oe === 1'b1) n_oe++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer(acr_pkg::CMD_WR, a, d, rd);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    host.xfer(acr_pkg::CMD_RD, a, 8'h00, rd);
    chk({8'h00, rd}, {8'h00, e});
  endtask
  // Single-cycle result pulses, then time for flags to settle
  task automatic ev(input int n);
    repeat (n) begin
      @(negedge clk) result_done = 1'b1;
      @(negedge clk) result_done = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog well beyond the expected run of about 72 us
  initial begin
    #400000;
    failures++;
    final_report;
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {launch, conv_busy, result_done, scan_done, auto_scan} = 5'h00;
    fifo_level = 4'h0;
    repeat (8) @(negedge clk);
    chk({core_clear, pin, ports}, 16'hC000);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    n_clear = 0;
    n_start = 0;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].r);
      chk({2'h0, ports}, {2'h0, rows[i].p});
    end
    // Software reset is refused while powered down
    wr(acr_pkg::OFS_SRST, acr_pkg::SRST_KEY);
    chk({n_clear[1:0], ports}, 16'h1AF7);
    wr(acr_pkg::OFS_INTEN, 8'h0F);
    wr(acr_pkg::OFS_SRST, acr_pkg::SRST_KEY);
    chk({n_clear[1:0], ports}, 16'h4000);
    rdc(acr_pkg::OFS_SETUP, 8'h00);
    // Fast average of four, level mode, active high
    wr(acr_pkg::OFS_INTEN, 8'h01);
    wr(acr_pkg::OFS_SETUP, 8'h28);
    ev(3);
    rdc(acr_pkg::OFS_STAT, 8'h00);
    ev(1);
    chk({15'h0, pin}, 16'h0001);
    rdc(acr_pkg::OFS_STAT, 8'h01);
    rdc(acr_pkg::OFS_INTEN, 8'h01);
    chk({15'h0, pin}, 16'h0000);
    // Full FIFO and a finished scan in auto mode
    wr(acr_pkg::OFS_INTEN, 8'h0E);
    @(negedge clk) {fifo_level, auto_scan, scan_done} = 6'h23;
    @(negedge clk) scan_done = 1'b0;
    rdc(acr_pkg::OFS_STAT, 8'h8F);
    rdc(acr_pkg::OFS_INTEN, 8'h0E);
    @(negedge clk) {fifo_level, auto_scan} = 5'h00;
    // Busy function, active low
    wr(acr_pkg::OFS_SETUP, 8'h04);
    @(negedge clk) conv_busy = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0, pin}, 16'h0000);
    conv_busy = 1'b0;
    // Pin start, then one read-started conversion with the pin ignored
    launch = 1'b1;
    repeat (6) @(negedge clk);
    launch = 1'b0;
    wr(acr_pkg::OFS_SETUP, 8'h19);
    @(negedge clk) launch = 1'b1;
    repeat (6) @(negedge clk);
    // The result read launches a conversion; its data bits read zero and are discarded
    host.xfer(acr_pkg::CMD_ADC, 4'h0, 8'h00, rd);
    chk(n_start[15:0], 16'h0002);
    // Edge mode: one pulse of the documented width
    wr(acr_pkg::OFS_INTEN, 8'h01);
    host.xfer(acr_pkg::CMD_RD, acr_pkg::OFS_INTEN, 8'h00, rd);
    n_high = 0;
    ev(1);
    repeat (40) @(negedge clk);
    chk(n_high[15:0], acr_pkg::PULSE_CYC[15:0]);
    chk({15'h0, n_oe != 0}, 16'h0001);
    // Hardware reset mid-run restores defaults and clears the core
    wr(acr_pkg::OFS_PAIR67, 8'h16);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk({core_clear, pin, ports}, 16'hC000);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    chk({core_clear, sdout_oe, ports}, 16'h0000);
    final_report;
  end
endmodule
